// >>> design/rfcb_pkg.sv
// Constants and carrier types shared by the flow control and bridge block
package rfcb_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses on the APB side)
   // ----------------------------------------------------------------
   localparam logic [7:0]  RFCB_OFS_DROP        = 8'hA0;
   localparam logic [7:0]  RFCB_OFS_CMD         = 8'hA4;
   localparam logic [7:0]  RFCB_OFS_DATA        = 8'hA8;
   localparam logic [7:0]  RFCB_OFS_AFC         = 8'hAC;
   localparam int          RFCB_ADDR_W          = 8;

   // Command register fields and reset values
   localparam int          RFCB_CMD_BUSY_BIT    = 31;
   localparam int          RFCB_CMD_RNW_BIT     = 30;
   localparam logic [31:0] RFCB_DROP_RST        = 32'h0000_0000;
   localparam logic [31:0] RFCB_DATA_RST        = 32'h0000_0000;
   localparam logic [31:0] RFCB_AFC_RST         = 32'h0000_0000;
   localparam logic [7:0]  RFCB_CSR_ADDR_RST    = 8'h00;
   localparam logic [31:0] RFCB_DROP_HALF_BELOW = 32'h7FFF_FFFF;

   // Receive FIFO level, in bytes; thresholds count 64-byte units
   localparam int          RFCB_LVL_W           = 14;
   localparam int          RFCB_LVL_UNIT_LSB    = 6;

   // Timing: clock period and jam durations
   localparam int unsigned RFCB_CLK_PERIOD_NS   = 50;
   localparam int unsigned RFCB_NS_PER_US       = 1000;
   localparam int unsigned RFCB_JAM_10M_XTRA_NS = 2200;
   localparam int          RFCB_JAM_CNT_W       = 14;

   // Jam duration in microseconds for each code at 100 Mb/s
   function automatic int unsigned rfcb_jam_us(input logic [3:0] code);
      case (code)
         4'h0:    return 5;
         4'h1:    return 10;
         4'h2:    return 15;
         4'h3:    return 25;
         default: return 50 * (int'(code) - 3);
      endcase
   endfunction : rfcb_jam_us

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] reserved;
      logic [7:0] fifo_high_threshold;
      logic [7:0] fifo_low_threshold;
      logic [3:0] jam_duration_code;
      logic       trigger_on_multicast;
      logic       trigger_on_broadcast;
      logic       trigger_on_own_address;
      logic       trigger_on_any_frame;
   } rfcb_auto_flow_control_config_t;

   typedef struct packed {
      logic        req;
      logic        bridge_read_not_write;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } rfcb_mac_req_t;

   typedef struct packed {
      logic start;
      logic multicast;
      logic broadcast;
      logic own_address;
   } rfcb_rx_frame_t;

   typedef enum logic {
      RFCB_BR_IDLE = 1'b0,
      RFCB_BR_BUSY = 1'b1
   } rfcb_br_state_t;

   typedef enum logic {
      RFCB_FC_CLEAR  = 1'b0,
      RFCB_FC_PAUSED = 1'b1
   } rfcb_fc_state_t;

endpackage : rfcb_pkg

// >>> design/rfcb_drop_counter.sv
// Clear-on-read dropped frame counter with halfway event
`timescale 1ns/10ps
module rfcb_drop_counter (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        count_inc,
   input  wire logic        count_clr,
   output logic [31:0]      count_r,
   output logic             half_event_r
);

   logic [31:0] count_nxt;
   logic        half_event_nxt;

   // Next count: a drop in the clearing cycle survives as one
   always_comb
   begin
      count_nxt      = count_clr ? rfcb_pkg::RFCB_DROP_RST : count_r;
      if (count_inc)
         count_nxt = count_nxt + 32'h0000_0001;
      half_event_nxt = count_inc && !count_clr &&
                       (count_r == rfcb_pkg::RFCB_DROP_HALF_BELOW);
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_r      <= rfcb_pkg::RFCB_DROP_RST;
         half_event_r <= 1'b0;
      end
      else
      begin
         count_r      <= count_nxt;
         half_event_r <= half_event_nxt;
      end
   end

endmodule : rfcb_drop_counter

// >>> design/rfcb_jam_timer.sv
// Half-duplex back-pressure (jam) duration timer
`timescale 1ns/10ps
module rfcb_jam_timer #(
   parameter int unsigned TIME_DIV = 1
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        start,
   input  wire logic        abort,
   input  wire logic [3:0]  code,
   input  wire logic        speed_100,
   output logic             active_r
);

   localparam int W = rfcb_pkg::RFCB_JAM_CNT_W;

   logic [W-1:0] remain_r;
   logic [W-1:0] remain_nxt;
   logic         active_nxt;

   // Cycles for a code; 10 Mb/s adds a fixed extra time
   function automatic logic [W-1:0] load_cycles(input logic [3:0] c,
                                                input logic       fast);
      int unsigned ns;
      int unsigned cyc;
      ns  = rfcb_pkg::rfcb_jam_us(c) * rfcb_pkg::RFCB_NS_PER_US;
      if (!fast)
         ns = ns + rfcb_pkg::RFCB_JAM_10M_XTRA_NS;
      cyc = ns / rfcb_pkg::RFCB_CLK_PERIOD_NS / TIME_DIV;
      if (cyc == 0)
         cyc = 1;
      return cyc[W-1:0];
   endfunction : load_cycles

   // Countdown; a new matching frame restarts the full period
   always_comb
   begin
      remain_nxt = remain_r;
      active_nxt = active_r;
      if (abort)
      begin
         remain_nxt = '0;
         active_nxt = 1'b0;
      end
      else if (start)
      begin
         remain_nxt = load_cycles(code, speed_100);
         active_nxt = 1'b1;
      end
      else if (active_r)
      begin
         remain_nxt = remain_r - {{(W-1){1'b0}}, 1'b1};
         active_nxt = (remain_r != {{(W-1){1'b0}}, 1'b1});
      end
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         remain_r <= '0;
         active_r <= 1'b0;
      end
      else
      begin
         remain_r <= remain_nxt;
         active_r <= active_nxt;
      end
   end

endmodule : rfcb_jam_timer

// >>> design/rfcb_top.sv
// Dropped frame counter, MAC register bridge and automatic flow control
`timescale 1ns/10ps
module rfcb_top #(
   parameter int unsigned JAM_TIME_DIV = 1
) (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic [7:0]                   paddr,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [31:0]                  pwdata,
   input  wire logic [3:0]                   pstrb,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic                         rx_frame_dropped,
   input  wire logic [13:0]                  rx_fifo_level,
   input  wire rfcb_pkg::rfcb_rx_frame_t     rx_frame,
   input  wire logic                         full_duplex,
   input  wire logic                         tx_enabled,
   input  wire logic                         speed_100,
   output rfcb_pkg::rfcb_mac_req_t           mac_req,
   input  wire logic                         mac_ack,
   input  wire logic [31:0]                  mac_rdata,
   output logic                              pause_req,
   output logic                              pause_zero_time,
   output logic                              jam_active,
   output logic                              drop_half_event
);

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic        setup_phase;
   logic        access_phase;
   logic        wr_take;
   logic        addr_ok;
   logic        hit_drop;
   logic        hit_cmd;
   logic        hit_data;
   logic        hit_afc;
   logic [31:0] wmask;

   // The slave answers after exactly one wait-free access phase
   assign setup_phase  = psel && !penable;
   assign access_phase = psel && penable && pready;
   assign wr_take      = access_phase && pwrite && addr_ok;
   assign hit_drop     = (paddr == rfcb_pkg::RFCB_OFS_DROP);
   assign hit_cmd      = (paddr == rfcb_pkg::RFCB_OFS_CMD);
   assign hit_data     = (paddr == rfcb_pkg::RFCB_OFS_DATA);
   assign hit_afc      = (paddr == rfcb_pkg::RFCB_OFS_AFC);
   assign addr_ok      = hit_drop || hit_cmd || hit_data || hit_afc;
   assign wmask        = {{8{pstrb[3]}}, {8{pstrb[2]}},
                          {8{pstrb[1]}}, {8{pstrb[0]}}};

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [31:0]                  prdata_r;
   logic [31:0]                  prdata_nxt;
   logic                         pready_r;
   logic                         pready_nxt;
   logic                         pslverr_r;
   logic                         pslverr_nxt;
   rfcb_pkg::rfcb_auto_flow_control_config_t      afc_r;
   rfcb_pkg::rfcb_auto_flow_control_config_t      afc_nxt;
   logic [31:0]                  bdata_r;
   logic [31:0]                  bdata_nxt;
   logic [7:0]                   csr_addr_r;
   logic [7:0]                   csr_addr_nxt;
   logic                         rnw_r;
   logic                         rnw_nxt;
   rfcb_pkg::rfcb_br_state_t     br_state_r;
   rfcb_pkg::rfcb_br_state_t     br_state_nxt;
   rfcb_pkg::rfcb_mac_req_t      mac_req_r;
   rfcb_pkg::rfcb_mac_req_t      mac_req_nxt;
   logic [31:0]                  drop_count;
   logic                         drop_clr;
   logic                         busy;
   logic [31:0]                  cmd_view;

   assign busy     = (br_state_r == rfcb_pkg::RFCB_BR_BUSY);
   assign cmd_view = {busy, rnw_r, 22'h00_0000, csr_addr_r};

   // read clears at the setup edge, the same edge that captures prdata
   assign drop_clr = setup_phase && !pwrite && hit_drop;

   // ----------------------------------------------------------------
   // Dropped frame counter
   // ----------------------------------------------------------------
   // counter instance
   rfcb_drop_counter u_drop (
      .pclk         (pclk),
      .presetn      (presetn),
      .count_inc    (rx_frame_dropped),
      .count_clr    (drop_clr),
      .count_r      (drop_count),
      .half_event_r (drop_half_event)
   );

   // ----------------------------------------------------------------
   // APB answer path
   // ----------------------------------------------------------------
   // Read data is captured at the setup edge, so the counter clear and
   // the returned snapshot happen together and no drop is lost
   always_comb
   begin
      pready_nxt  = setup_phase;
      pslverr_nxt = setup_phase && !addr_ok;
      prdata_nxt  = prdata_r;
      if (setup_phase)
      begin
         prdata_nxt = 32'h0000_0000;
         if (!pwrite)
         begin
            case (paddr)
               rfcb_pkg::RFCB_OFS_DROP: prdata_nxt = drop_count;
               rfcb_pkg::RFCB_OFS_CMD:  prdata_nxt = cmd_view;
               rfcb_pkg::RFCB_OFS_DATA: prdata_nxt = bdata_r;
               rfcb_pkg::RFCB_OFS_AFC:  prdata_nxt = {8'h00, afc_r[23:0]};
               default:                 prdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;

   // ----------------------------------------------------------------
   // Flow control configuration register
   // ----------------------------------------------------------------
   always_comb
   begin
      afc_nxt = afc_r;
      if (wr_take && hit_afc)
         afc_nxt = (afc_r & ~wmask) | (pwdata & wmask);
      afc_nxt.reserved = 8'h00;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         afc_r <= rfcb_pkg::RFCB_AFC_RST;
      else
         afc_r <= afc_nxt;
   end

   // ----------------------------------------------------------------
   // MAC register bridge
   // ----------------------------------------------------------------
   // Data and command writes while busy are dropped: the access in flight already uses
   // the address and data, and changing them would corrupt it
   always_comb
   begin
      br_state_nxt = br_state_r;
      mac_req_nxt  = mac_req_r;
      bdata_nxt    = bdata_r;
      csr_addr_nxt = csr_addr_r;
      rnw_nxt      = rnw_r;
      case (br_state_r)
         rfcb_pkg::RFCB_BR_IDLE:
         begin
            if (wr_take && hit_data)
               bdata_nxt = (bdata_r & ~wmask) | (pwdata & wmask);
            if (wr_take && hit_cmd)
            begin
               if (pstrb[0])
                  csr_addr_nxt = pwdata[7:0];
               if (pstrb[3])
                  rnw_nxt = pwdata[rfcb_pkg::RFCB_CMD_RNW_BIT];
               if (pstrb[3] && pwdata[rfcb_pkg::RFCB_CMD_BUSY_BIT])
               begin
                  br_state_nxt                    = rfcb_pkg::RFCB_BR_BUSY;
                  mac_req_nxt.req                 = 1'b1;
                  mac_req_nxt.bridge_read_not_write =
                     pwdata[rfcb_pkg::RFCB_CMD_RNW_BIT];
                  mac_req_nxt.addr  = pstrb[0] ? pwdata[7:0] : csr_addr_r;
                  mac_req_nxt.wdata = bdata_r;
               end
            end
         end
         rfcb_pkg::RFCB_BR_BUSY:
         begin
            // busy held until the MAC answers
            if (mac_ack)
            begin
               br_state_nxt    = rfcb_pkg::RFCB_BR_IDLE;
               mac_req_nxt.req = 1'b0;
               // data lands no later than busy clears
               if (rnw_r)
                  bdata_nxt = mac_rdata;
            end
         end
         default:
         begin
            br_state_nxt    = rfcb_pkg::RFCB_BR_IDLE;
            mac_req_nxt.req = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         br_state_r <= rfcb_pkg::RFCB_BR_IDLE;
         mac_req_r  <= '0;
         bdata_r    <= rfcb_pkg::RFCB_DATA_RST;
         csr_addr_r <= rfcb_pkg::RFCB_CSR_ADDR_RST;
         rnw_r      <= 1'b0;
      end
      else
      begin
         br_state_r <= br_state_nxt;
         mac_req_r  <= mac_req_nxt;
         bdata_r    <= bdata_nxt;
         csr_addr_r <= csr_addr_nxt;
         rnw_r      <= rnw_nxt;
      end
   end

   assign mac_req = mac_req_r;

   // ----------------------------------------------------------------
   // Flow control: threshold compare
   // ----------------------------------------------------------------
   logic [7:0] level_units;
   logic       at_high;
   logic       below_low;
   logic       frame_match;

   assign level_units = rx_fifo_level[rfcb_pkg::RFCB_LVL_W-1:
                                      rfcb_pkg::RFCB_LVL_UNIT_LSB];
   assign at_high     = (level_units >= afc_r.fifo_high_threshold);
   assign below_low   = (level_units < afc_r.fifo_low_threshold);

   assign frame_match = afc_r.trigger_on_any_frame ||
                        (afc_r.trigger_on_multicast   && rx_frame.multicast) ||
                        (afc_r.trigger_on_broadcast   && rx_frame.broadcast) ||
                        (afc_r.trigger_on_own_address && rx_frame.own_address);

   // ----------------------------------------------------------------
   // Flow control: full-duplex pause frames
   // ----------------------------------------------------------------
   rfcb_pkg::rfcb_fc_state_t fc_state_r;
   rfcb_pkg::rfcb_fc_state_t fc_state_nxt;
   logic                     pause_req_r;
   logic                     pause_req_nxt;
   logic                     pause_zero_r;
   logic                     pause_zero_nxt;
   logic                     fd_ok;

   assign fd_ok = tx_enabled && full_duplex && afc_r.trigger_on_any_frame;

   // One pause on the way up, one zero-time pause on the way down
   always_comb
   begin
      fc_state_nxt   = fc_state_r;
      pause_req_nxt  = 1'b0;
      pause_zero_nxt = pause_zero_r;
      case (fc_state_r)
         rfcb_pkg::RFCB_FC_CLEAR:
         begin
            if (fd_ok && at_high)
            begin
               fc_state_nxt   = rfcb_pkg::RFCB_FC_PAUSED;
               pause_req_nxt  = 1'b1;
               pause_zero_nxt = 1'b0;
            end
         end
         rfcb_pkg::RFCB_FC_PAUSED:
         begin
            // zero pause only after a real one
            if (fd_ok && below_low)
            begin
               fc_state_nxt   = rfcb_pkg::RFCB_FC_CLEAR;
               pause_req_nxt  = 1'b1;
               pause_zero_nxt = 1'b1;
            end
         end
         default:
            fc_state_nxt = rfcb_pkg::RFCB_FC_CLEAR;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fc_state_r   <= rfcb_pkg::RFCB_FC_CLEAR;
         pause_req_r  <= 1'b0;
         pause_zero_r <= 1'b0;
      end
      else
      begin
         fc_state_r   <= fc_state_nxt;
         pause_req_r  <= pause_req_nxt;
         pause_zero_r <= pause_zero_nxt;
      end
   end

   assign pause_req       = pause_req_r;
   assign pause_zero_time = pause_zero_r;

   // ----------------------------------------------------------------
   // Flow control: half-duplex back pressure
   // ----------------------------------------------------------------
   logic hd_start;
   logic hd_abort;

   assign hd_start = tx_enabled && !full_duplex && at_high &&
                     rx_frame.start && frame_match;
   // stop jamming in full duplex or transmitter off
   assign hd_abort = !tx_enabled || full_duplex;

   rfcb_jam_timer #(
      .TIME_DIV (JAM_TIME_DIV)
   ) u_jam (
      .pclk      (pclk),
      .presetn   (presetn),
      .start     (hd_start),
      .abort     (hd_abort),
      .code      (afc_r.jam_duration_code),
      .speed_100 (speed_100),
      .active_r  (jam_active)
   );

endmodule : rfcb_top

// >>> tb/rfcb_assertions.sv
// Port checker for the flow control and bridge block
`timescale 1ns/10ps
module rfcb_assertions (
   input wire logic pclk, presetn, psel, penable, pwrite, pready,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire rfcb_pkg::rfcb_mac_req_t mac_req,
   input wire logic mac_ack, full_duplex, tx_enabled,
   input wire logic pause_req, jam_active, drop_half_event
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Slave never inserts wait states
   a_apb_no_wait: assert property (psel && !penable |=> pready)
      else $error("pready late");
   a_cmd_launch: assert property (
      psel && penable && pready && pwrite && paddr == 8'hA4
      && pwdata[31] && pstrb == 4'hF && !mac_req.req
      |=> mac_req.req && mac_req.addr == $past(pwdata[7:0])
      && mac_req.bridge_read_not_write == $past(pwdata[30]))
      else $error("bridge launch wrong");
   a_req_held: assert property (
      mac_req.req && !mac_ack |=> $stable(mac_req))
      else $error("request changed before ack");
   a_req_release: assert property (
      mac_req.req && mac_ack |=> !mac_req.req)
      else $error("request kept after ack");
   a_tx_off_quiet: assert property (
      !tx_enabled |=> !pause_req && !jam_active)
      else $error("flow control with tx off");
   a_fd_no_jam: assert property (
      full_duplex |=> !jam_active)
      else $error("jam in full duplex");
   a_pause_single: assert property (
      pause_req |-> $past(full_duplex && tx_enabled) ##1 !pause_req)
      else $error("pause pulse wrong");
   a_jam_cause: assert property (
      $rose(jam_active) |-> $past(!full_duplex && tx_enabled))
      else $error("jam without cause");
   a_half_pulse: assert property (
      drop_half_event |=> !drop_half_event)
      else $error("halfway event too long");
endmodule : rfcb_assertions

// >>> tb/rfcb_mac_model.sv
// Behavioural MAC register file answering bridge requests
`timescale 1ns/10ps
module rfcb_mac_model (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire rfcb_pkg::rfcb_mac_req_t mac_req,
   input  wire logic [3:0]              mdel,
   output logic                         mac_ack,
   output logic [31:0]                  mac_rdata
);
   logic [31:0] mem [256];
   int          cnt;
   // Waits mdel cycles; data toggles outside the ack so stale use shows
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         mac_ack <= 0;
         cnt <= 0;
         mac_rdata <= 32'h5A5A_A5A5;
      end
      else
      begin
         mac_ack <= 0;
         mac_rdata <= ~mac_rdata;
         if (mac_req.req && !mac_ack && cnt < mdel) cnt <= cnt + 1;
         else if (mac_req.req && !mac_ack)
         begin
            cnt <= 0;
            mac_ack <= 1;
            if (mac_req.bridge_read_not_write) mac_rdata <= mem[mac_req.addr];
            else mem[mac_req.addr] <= mac_req.wdata;
         end
      end
endmodule : rfcb_mac_model

// >>> tb/tb.sv
// Self-checking bench for the flow control and bridge block
`timescale 1ns/10ps
module tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0, a;
   logic [31:0] pwdata = 0, prdata, mac_rdata, r, d;
   logic pready, pslverr, mac_ack, pause_req, pause_zero_time, e;
   logic jam_active, drop_half_event, rx_frame_dropped = 0;
   logic full_duplex = 0, tx_enabled = 0, speed_100 = 0;
   logic [13:0] rx_fifo_level = 0;
   logic [3:0]  mdel = 0;
   rfcb_pkg::rfcb_rx_frame_t rx_frame = 0;
   rfcb_pkg::rfcb_mac_req_t  mac_req;
   int seed = 78, mismatches = 0, n_checks = 0, n_pause = 0, n_zero = 0;
   int jam_len = 0, i, t, lv, ep, ez, pz, cnt, n, n_half = 0;
   int tl[6] = '{0, 255, 256, 256, 128, 127};
   rfcb_top #(.JAM_TIME_DIV(100)) uut (.pstrb(4'hF), .*);
   rfcb_mac_model mac (.*);
   initial forever #25 pclk = ~pclk;
   // Count pause pulses and jam cycles as the design shows them
   always @(posedge pclk)
   begin
      if (pause_req === 1) begin n_pause++; n_zero += pause_zero_time; end
      if (jam_active === 1) jam_len++;
      if (drop_half_event === 1) n_half++;
   end
   task chk(input logic [31:0] g, x);
      n_checks++;
      if (g !== x)
      begin
         mismatches++;
         $display("Error at %0t: got %h exp %h", $time, g, x);
      end
   endtask : chk
   task test_done;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   task tk(input int k);
      repeat (k) @(posedge pclk);
   endtask : tk
   // One APB transfer; request held until pready seen at an edge
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      psel <= 1; pwrite <= w; paddr <= ad; pwdata <= wd;
      @(posedge pclk) penable <= 1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1 && n < 20);
      if (n >= 20) begin mismatches++; test_done; end
      r = prdata; e = pslverr; psel <= 0; penable <= 0;
      // Let an edge pass so the next call never reassigns psel at once
      tk(1);
   endtask : apb
   // host polls busy and leaves command and data alone until idle
   task wait_idle;
      cnt = 0;
      do begin apb(0, 8'hA4, 0); cnt++; end while (r[31] !== 0 && cnt < 40);
      if (cnt >= 40) begin mismatches++; test_done; end
   endtask : wait_idle
   task frame(input logic [2:0] ty);
      jam_len = 0; rx_frame <= {1'b1, ty};
      @(posedge pclk) rx_frame <= 0;
      tk(130);
   endtask : frame
   function automatic int jn(int c, int s);
      int us = c < 3 ? 5 * (c + 1) : (c == 3 ? 25 : 50 * (c - 3));
      jn = (us * 1000 + (s ? 0 : 2200)) / 5000;
      if (jn == 0) jn = 1;
   endfunction : jn
   initial
   begin
      tk(3);
      presetn <= 1;
      tk(1);
      for (i = 0; i < 5; i++)
      begin
         apb(0, 8'(8'hA0 + 4 * i), 0);
         chk(r, 0);
         chk(e, i == 4);
      end
      $display("reset test done");
      cnt = 0;
      repeat (40)
      begin
         t = $random(seed) & 1; rx_frame_dropped <= t[0]; cnt += t;
         tk(1);
      end
      rx_frame_dropped <= 0;
      apb(0, 8'hA0, 0); chk(r, cnt);
      apb(0, 8'hA0, 0); chk(r, 0);
      $display("drop test done");
      for (i = 0; i < 4; i++)
      begin
         a = $random(seed); d = $random(seed); mdel <= 4'(4 * i);
         apb(1, 8'hA8, d); apb(1, 8'hA4, {2'b10, 22'h0, a});
         if (i > 0) begin apb(0, 8'hA4, 0); chk(r[31], 1); end
         wait_idle;
         apb(1, 8'hA4, {2'b11, 22'h0, a}); wait_idle;
         chk(r, {2'b01, 22'h0, a});
         apb(0, 8'hA8, 0); chk(r, d);
      end
      $display("bridge test done");
      full_duplex <= 1; pz = 0; ep = 0; ez = 0;
      apb(1, 8'hAC, 32'h0004_0201);
      for (i = 0; i < 30; i++)
      begin
         lv = i < 6 ? tl[i] : {$random(seed)} % 400; t = i != 2;
         tx_enabled <= t[0]; rx_fifo_level <= 14'(lv);
         tk(8);
         if (t && lv / 64 >= 4 && !pz) begin ep++; pz = 1; end
         else if (t && pz && lv / 64 < 2) begin ep++; ez++; pz = 0; end
         chk(n_pause, ep);
         chk(n_zero, ez);
      end
      $display("pause test done");
      full_duplex <= 0; rx_fifo_level <= 14'd256;
      for (t = 0; t < 4; t++)
      begin
         d = $random(seed); speed_100 <= d[4];
         apb(1, 8'hAC, {16'h0402, d[3:0], 4'(1 << t)});
         if (t > 0)
         begin
            frame(3'(~(1 << (t - 1))));
            chk(jam_len, 0);
         end
         frame(t ? 3'(1 << (t - 1)) : 3'b000);
         chk(jam_len, jn(d[3:0], d[4]));
      end
      tx_enabled <= 0; frame(3'b100); chk(jam_len, 0);
      $display("jam test done");
      chk(n_half, 0);
      test_done;
   end
endmodule : tb
bind rfcb_top rfcb_assertions chk_i (.*);
